// ---- logic/hdlc_timeslot_bit_mapper.sv ----
// Maps HDLC serial bits into and out of E1 Sa bits or DS0 timeslots, plus the transmit FIFO.
// Assumes framer and HDLC controller share clk and present one bit per strobe cycle.
`timescale 1ns/1ps

module hdlc_bit_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_q, rd_q;
	logic [CW-1:0] count_q, count_d;
	logic ready_q;
	wire push = in_valid & ready_q;
	wire pop = out_valid & out_ready;

	assign in_ready = ready_q;
	assign out_valid = count_q != '0;
	assign out_data = mem[rd_q];
	assign count_d = count_q + CW'(push) - CW'(pop);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
			ready_q <= 1'h1;
		end else begin
			wr_q <= wr_q + PW'(push);
			rd_q <= rd_q + PW'(pop);
			count_q <= count_d;
			// Registered so the upstream ready is a clean flop
			ready_q <= count_d != CW'(DEPTH);
		end
	end
endmodule

module hdlc_timeslot_bit_mapper (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Receive framer stream
	input wire logic rx_strobe,
	input wire logic rx_data,
	input wire logic [4:0] rx_ts,
	input wire logic [2:0] rx_bit_idx,
	input wire logic rx_is_sa,
	input wire logic [3:0] rx_sa_num,
	// Toward HDLC receiver
	output logic hdlc_rx_valid,
	output logic hdlc_rx_bit,
	// Transmit framer stream
	input wire logic tx_strobe,
	input wire logic tx_data,
	input wire logic [4:0] tx_ts,
	input wire logic [2:0] tx_bit_idx,
	input wire logic tx_is_sa,
	input wire logic [3:0] tx_sa_num,
	// Outgoing transmit stream
	output logic tx_out_valid,
	output logic tx_out_bit,
	output logic tx_hdlc_inserted,
	output logic tx_underrun,
	// From HDLC transmitter
	input wire logic hdlc_tx_valid,
	input wire logic hdlc_tx_bit,
	output logic hdlc_tx_ready
);
	logic [7:0] rx_map_q, rx_mask_q, tx_map_q, tx_mask_q, rx_sa_q, rdata_q;
	logic [31:0] rx_blk_q, tx_blk_q;
	logic hdlc_rx_valid_q, hdlc_rx_bit_q, tx_out_valid_q, tx_out_bit_q, tx_ins_q, tx_udr_q;
	logic fifo_valid, fifo_bit;

	// Sa4 sits on enable bit 4, Sa8 on bit 0
	function automatic logic sa_hit(input logic [4:0] en, input logic is_sa, input logic [3:0] num);
		logic [3:0] off;
		off = 4'h8 - num;
		sa_hit = is_sa && num >= 4'h4 && num <= 4'h8 && en[off[2:0]];
	endfunction

	function automatic logic ts_hit(input logic mode, input logic [4:0] ch, input logic [31:0] blk,
		input logic [4:0] ts);
		ts_hit = mode ? blk[ts] : (ch == ts);
	endfunction

	// Register decode
	wire hit_blk_rx = reg_addr[7:2] == hdlc_map_pkg::ADDR_RX_BLK0[7:2];
	wire hit_blk_tx = reg_addr[7:2] == hdlc_map_pkg::ADDR_TX_BLK0[7:2];
	wire [7:0] rd_mux =
		reg_addr == hdlc_map_pkg::ADDR_RX_MAP ? rx_map_q :
		reg_addr == hdlc_map_pkg::ADDR_RX_MASK ? rx_mask_q :
		reg_addr == hdlc_map_pkg::ADDR_TX_MAP ? tx_map_q :
		reg_addr == hdlc_map_pkg::ADDR_TX_MASK ? tx_mask_q :
		reg_addr == hdlc_map_pkg::ADDR_RX_SA ? rx_sa_q :
		hit_blk_rx ? rx_blk_q[8*reg_addr[1:0] +: 8] :
		hit_blk_tx ? tx_blk_q[8*reg_addr[1:0] +: 8] : 8'h00;

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_map_q <= hdlc_map_pkg::RST_REG;
			rx_mask_q <= hdlc_map_pkg::RST_REG;
			tx_map_q <= hdlc_map_pkg::RST_REG;
			tx_mask_q <= hdlc_map_pkg::RST_REG;
			rx_sa_q <= hdlc_map_pkg::RST_REG;
			rx_blk_q <= hdlc_map_pkg::RST_BLK;
			tx_blk_q <= hdlc_map_pkg::RST_BLK;
			rdata_q <= hdlc_map_pkg::RST_REG;
		end else begin
			if (reg_wr && reg_addr == hdlc_map_pkg::ADDR_RX_MAP) rx_map_q <= reg_wdata;
			if (reg_wr && reg_addr == hdlc_map_pkg::ADDR_RX_MASK) rx_mask_q <= reg_wdata;
			if (reg_wr && reg_addr == hdlc_map_pkg::ADDR_TX_MAP) tx_map_q <= reg_wdata;
			if (reg_wr && reg_addr == hdlc_map_pkg::ADDR_TX_MASK) tx_mask_q <= reg_wdata;
			if (reg_wr && reg_addr == hdlc_map_pkg::ADDR_RX_SA) rx_sa_q <= reg_wdata;
			if (reg_wr && hit_blk_rx) rx_blk_q[8*reg_addr[1:0] +: 8] <= reg_wdata;
			if (reg_wr && hit_blk_tx) tx_blk_q[8*reg_addr[1:0] +: 8] <= reg_wdata;
			if (reg_rd) rdata_q <= rd_mux;
		end
	end

	// Receive selection; Sa bits are never subject to the DS0 mask
	wire rx_ts_sel = ~rx_is_sa & ~rx_mask_q[rx_bit_idx] &
		ts_hit(rx_map_q[hdlc_map_pkg::MODE_BIT], rx_map_q[4:0], rx_blk_q, rx_ts);
	wire rx_map_sel = rx_map_q[hdlc_map_pkg::SAD_BIT] ? rx_ts_sel :
		sa_hit(rx_map_q[4:0], rx_is_sa, rx_sa_num);
	wire rx_dflt_sel = sa_hit(rx_sa_q[hdlc_map_pkg::SA_FIELD_LSB +: 5], rx_is_sa, rx_sa_num);
	wire rx_sel = rx_strobe & (rx_map_q[hdlc_map_pkg::SRC_BIT] ? rx_map_sel : rx_dflt_sel);

	// Transmit selection, gated by the enable before the route select is looked at
	wire tx_ts_sel = ~tx_is_sa & ~tx_mask_q[tx_bit_idx] &
		ts_hit(tx_map_q[hdlc_map_pkg::MODE_BIT], tx_map_q[4:0], tx_blk_q, tx_ts);
	wire tx_route = tx_map_q[hdlc_map_pkg::SAD_BIT] ? tx_ts_sel :
		sa_hit(tx_map_q[4:0], tx_is_sa, tx_sa_num);
	wire tx_sel = tx_strobe & tx_map_q[7] & tx_route;
	wire tx_pop = tx_sel & fifo_valid;

	hdlc_bit_fifo #(.WIDTH(hdlc_map_pkg::FIFO_WIDTH), .DEPTH(hdlc_map_pkg::FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(hdlc_tx_valid),
		.in_ready(hdlc_tx_ready),
		.in_data(hdlc_tx_bit),
		.out_valid(fifo_valid),
		.out_ready(tx_sel),
		.out_data(fifo_bit)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			hdlc_rx_valid_q <= 1'h0;
			hdlc_rx_bit_q <= 1'h0;
			tx_out_valid_q <= 1'h0;
			tx_out_bit_q <= 1'h0;
			tx_ins_q <= 1'h0;
			tx_udr_q <= 1'h0;
		end else begin
			hdlc_rx_valid_q <= rx_sel;
			hdlc_rx_bit_q <= rx_data;
			tx_out_valid_q <= tx_strobe;
			// Empty FIFO sends mark idle rather than stalling the line
			tx_out_bit_q <= tx_sel ? (fifo_valid ? fifo_bit : hdlc_map_pkg::TX_IDLE_BIT) : tx_data;
			tx_ins_q <= tx_sel;
			tx_udr_q <= tx_sel & ~fifo_valid;
		end
	end

	assign reg_rdata = rdata_q;
	assign hdlc_rx_valid = hdlc_rx_valid_q;
	assign hdlc_rx_bit = hdlc_rx_bit_q;
	assign tx_out_valid = tx_out_valid_q;
	assign tx_out_bit = tx_out_bit_q;
	assign tx_hdlc_inserted = tx_ins_q;
	assign tx_underrun = tx_udr_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_rx_mask_drop: assert property (rx_strobe && rx_map_q[7] && rx_map_q[6]
		&& !rx_is_sa && rx_mask_q[rx_bit_idx] |=> !hdlc_rx_valid) else $error("masked receive bit reached HDLC");
	a_tx_mask_keep: assert property (tx_strobe && !tx_is_sa && tx_map_q[6] && tx_mask_q[tx_bit_idx]
		|=> !tx_hdlc_inserted && tx_out_bit == $past(tx_data)) else $error("masked transmit bit replaced");
	a_tx_off_pass: assert property (tx_strobe && !tx_map_q[7]
		|=> tx_out_valid && !tx_hdlc_inserted && tx_out_bit == $past(tx_data)) else $error("insert while disabled");
	a_tx_off_route: assert property (!tx_map_q[7] && !$past(tx_map_q[7]) |-> !tx_hdlc_inserted)
		else $error("route select used while disabled");
	a_tx_sa_insert: assert property (tx_strobe && tx_map_q[7] && !tx_map_q[6]
		&& sa_hit(tx_map_q[4:0], tx_is_sa, tx_sa_num) |=> tx_hdlc_inserted) else $error("Sa bit not inserted");
	a_tx_sa_only: assert property (tx_strobe && tx_map_q[7] && !tx_map_q[6] && !tx_is_sa
		|=> !tx_hdlc_inserted) else $error("timeslot used in Sa mode");
	a_tx_single_ts: assert property (tx_strobe && tx_map_q[7:5] == 3'h6 && !tx_is_sa
		&& !tx_mask_q[tx_bit_idx] |=> tx_hdlc_inserted == ($past(tx_ts) == $past(tx_map_q[4:0])))
		else $error("single timeslot choice wrong");
	a_tx_block_ts: assert property (tx_strobe && tx_map_q[7:5] == 3'h7 && !tx_is_sa && !tx_mask_q[tx_bit_idx]
		|=> tx_hdlc_inserted == $past(tx_blk_q[tx_ts])) else $error("block timeslot choice wrong");
	a_rx_sa_default: assert property (rx_strobe && !rx_map_q[7]
		|=> hdlc_rx_valid == $past(rx_dflt_sel) && hdlc_rx_bit == $past(rx_data)) else $error("default Sa path wrong");
	a_rx_sa_map: assert property (rx_strobe && rx_map_q[7:6] == 2'h2
		|=> hdlc_rx_valid == $past(sa_hit(rx_map_q[4:0], rx_is_sa, rx_sa_num))) else $error("receive Sa map wrong");
	a_rx_ts_pick: assert property (rx_strobe && rx_map_q[7:6] == 2'h3 && !rx_is_sa && !rx_mask_q[rx_bit_idx]
		|=> hdlc_rx_valid == $past(ts_hit(rx_map_q[5], rx_map_q[4:0], rx_blk_q, rx_ts))) else $error("rx slot wrong");
	a_tx_fifo_order: assert property (tx_pop |=> tx_hdlc_inserted && !tx_underrun
		&& tx_out_bit == $past(fifo_bit)) else $error("HDLC bit not taken in order");
	a_tx_unsel_pass: assert property (tx_strobe && !tx_sel |=> tx_out_bit == $past(tx_data))
		else $error("unselected bit altered");

	c_tx_block_insert: cover property (tx_pop && tx_map_q[7:5] == 3'h7);
	c_tx_underrun: cover property (tx_underrun);
	c_rx_ts_masked: cover property (rx_strobe && rx_map_q[7:6] == 2'h3 && rx_mask_q[rx_bit_idx] && !rx_is_sa);
	c_fifo_full: cover property (!hdlc_tx_ready);
endmodule

// ---- logic/hdlc_map_pkg.sv ----
// Constants for the HDLC timeslot and Sa bit mapper.
// Assumes a byte-wide host register port and a framer that strobes one bit at a time.
package hdlc_map_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_RX_MAP = 8'hb8;
	localparam logic [7:0] ADDR_RX_MASK = 8'hb9;
	localparam logic [7:0] ADDR_TX_MAP = 8'hba;
	localparam logic [7:0] ADDR_TX_MASK = 8'hbb;
	localparam logic [7:0] ADDR_RX_BLK0 = 8'hc0;
	localparam logic [7:0] ADDR_TX_BLK0 = 8'hc4;
	localparam logic [7:0] ADDR_RX_SA = 8'hc8;
	// Mapping control fields
	localparam int SRC_BIT = 7;
	localparam int SAD_BIT = 6;
	localparam int MODE_BIT = 5;
	localparam int SA_FIELD_LSB = 3;
	// Values after reset
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [31:0] RST_BLK = 32'h0000_0000;
	// Bit sent when a chosen position finds no HDLC data
	localparam logic TX_IDLE_BIT = 1'h1;
	// Transmit FIFO shape
	localparam int FIFO_WIDTH = 1;
	localparam int FIFO_DEPTH = 8;
endpackage

// ---- dv/hdlc_tx_src.sv ----
// Behavioural HDLC transmitter offering single bits to the mapper.
// Assumes ready is sampled on the rising edge.
`timescale 1ns/1ps
module hdlc_tx_src (
	// Clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] rate,
	// Bit handshake
	input wire logic hdlc_tx_ready,
	output logic hdlc_tx_valid,
	output logic hdlc_tx_bit
);
	// A refused bit is held; rate 0 stops offers so the FIFO drains
	always @(posedge clk) begin
		if (rst) begin
			hdlc_tx_valid <= 1'h0;
			hdlc_tx_bit <= 1'h0;
		end else if (!hdlc_tx_valid || hdlc_tx_ready) begin
			hdlc_tx_valid <= rate == 2'h2 || (rate == 2'h1 && $urandom % 4 == 0);
			hdlc_tx_bit <= 1'($urandom);
		end
	end
endmodule

// ---- dv/hdlc_timeslot_bit_mapper_tb_top.sv ----
// Self-checking bench for the mapper, compared with a queue model.
// Assumes one-cycle registered answers and the hdlc_tx_src partner.
`timescale 1ns/1ps
module hdlc_timeslot_bit_mapper_tb_top;
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_strobe = 0, rx_data = 0, rx_is_sa = 0, arm = 0;
	logic tx_strobe = 0, tx_data = 0, tx_is_sa = 0, hdlc_tx_valid, hdlc_tx_bit, hdlc_tx_ready;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, e_rdv, sh [0:255];
	logic [4:0] rx_ts = 0, tx_ts = 0;
	logic [2:0] rx_bit_idx = 0, tx_bit_idx = 0;
	logic [3:0] rx_sa_num = 4'h4, tx_sa_num = 4'h4;
	logic [1:0] rate = 0;
	logic hdlc_rx_valid, hdlc_rx_bit, tx_out_valid, tx_out_bit, tx_hdlc_inserted, tx_underrun;
	logic e_rv, e_rb, e_tv, e_tb, e_ti, e_tu, e_rd;
	logic q [$];
	int err_total = 0, total_checks = 0;
	logic [7:0] cfg [7] = '{8'h00, 8'h40, 8'h9f, 8'h94, 8'hc5, 8'hc0, 8'he0};
	hdlc_timeslot_bit_mapper u_dut (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.rx_strobe, .rx_data, .rx_ts, .rx_bit_idx, .rx_is_sa, .rx_sa_num, .hdlc_rx_valid, .hdlc_rx_bit,
		.tx_strobe, .tx_data, .tx_ts, .tx_bit_idx, .tx_is_sa, .tx_sa_num, .tx_out_valid, .tx_out_bit,
		.tx_hdlc_inserted, .tx_underrun, .hdlc_tx_valid, .hdlc_tx_bit, .hdlc_tx_ready);
	hdlc_tx_src u_src (.clk, .rst, .rate, .hdlc_tx_ready, .hdlc_tx_valid, .hdlc_tx_bit);
	initial forever #2 clk = ~clk;
	function automatic logic ts_pick(logic [7:0] base, logic [7:0] m, logic [7:0] mk, logic [4:0] ts, logic [2:0] ix);
		logic [7:0] blk;
		blk = sh[base + 8'(ts[4:3])];
		return (m[5] ? blk[ts[2:0]] : ts == m[4:0]) && !mk[ix];
	endfunction
	function automatic logic rx_pick();
		logic [7:0] m;
		m = sh[hdlc_map_pkg::ADDR_RX_MAP];
		if (rx_is_sa) return m[7] ? !m[6] && m[8 - rx_sa_num] : sh[hdlc_map_pkg::ADDR_RX_SA][11 - rx_sa_num];
		return m[7] && m[6] && ts_pick(hdlc_map_pkg::ADDR_RX_BLK0, m, sh[hdlc_map_pkg::ADDR_RX_MASK], rx_ts, rx_bit_idx);
	endfunction
	function automatic logic tx_pick();
		logic [7:0] m;
		m = sh[hdlc_map_pkg::ADDR_TX_MAP];
		if (!m[7]) return 1'h0;
		if (tx_is_sa) return !m[6] && m[8 - tx_sa_num];
		return m[6] && ts_pick(hdlc_map_pkg::ADDR_TX_BLK0, m, sh[hdlc_map_pkg::ADDR_TX_MASK], tx_ts, tx_bit_idx);
	endfunction
	task automatic chk(string n, logic [7:0] exp, logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
	endtask
	// Model reads pre-edge inputs, so a write only counts from the next strobe
	always @(posedge clk) begin
		arm = 1'h1;
		if (rst) begin
			q.delete();
			foreach (sh[k]) sh[k] = 8'h00;
			{e_rv, e_tv, e_rd} = 3'h0;
		end else begin
			e_rv = rx_strobe && rx_pick();
			e_rb = rx_data;
			e_tv = tx_strobe;
			e_ti = tx_strobe && tx_pick();
			e_tu = e_ti && q.size() == 0;
			e_tb = !e_ti ? tx_data : (e_tu ? hdlc_map_pkg::TX_IDLE_BIT : q.pop_front());
			if (hdlc_tx_valid && hdlc_tx_ready) q.push_back(hdlc_tx_bit);
			e_rd = reg_rd;
			e_rdv = ((reg_addr >= hdlc_map_pkg::ADDR_RX_MAP && reg_addr <= hdlc_map_pkg::ADDR_TX_MASK) ||
				(reg_addr >= hdlc_map_pkg::ADDR_RX_BLK0 && reg_addr <= hdlc_map_pkg::ADDR_RX_SA)) ? sh[reg_addr] : 8'h00;
			if (reg_wr) sh[reg_addr] = reg_wdata;
			sh[8'h10] = 8'h00;
		end
	end
	always @(negedge clk) begin
		if (arm) begin
			chk("hdlc_rx_valid", e_rv, hdlc_rx_valid);
			if (e_rv) chk("hdlc_rx_bit", e_rb, hdlc_rx_bit);
			chk("tx_out_valid", e_tv, tx_out_valid);
			if (e_tv) chk("tx_out_bit", e_tb, tx_out_bit);
			if (e_tv) chk("tx_hdlc_inserted", e_ti, tx_hdlc_inserted);
			if (e_tv) chk("tx_underrun", e_tu, tx_underrun);
			chk("hdlc_tx_ready", q.size() < hdlc_map_pkg::FIFO_DEPTH, hdlc_tx_ready);
			if (e_rd) chk("reg_rdata", e_rdv, reg_rdata);
		end
	end
	always @(posedge clk) begin
		rx_strobe <= $urandom % 4 != 0;
		{rx_data, rx_ts, rx_bit_idx} <= 9'($urandom);
		rx_is_sa <= $urandom % 6 == 0;
		rx_sa_num <= 4'(4 + $urandom % 5);
		tx_strobe <= $urandom % 4 != 0;
		{tx_data, tx_ts, tx_bit_idx} <= 9'($urandom);
		tx_is_sa <= $urandom % 6 == 0;
		tx_sa_num <= 4'(4 + $urandom % 5);
	end
	initial begin
		#50000;
		err_total++;
		results();
	end
	initial begin
		void'($urandom(24047));
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		for (int a = 8'hb8; a <= 8'hc9; a++) rd(8'(a));
		wr(8'h10, 8'hff);
		rd(8'h10);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 7; i++) begin
				rate <= 2'((i + p) % 3);
				wr(hdlc_map_pkg::ADDR_TX_MAP, cfg[i]);
				wr(hdlc_map_pkg::ADDR_RX_MAP, cfg[i]);
				for (int k = 8'hb9; k <= 8'hc8; k += (k == 8'hb9 ? 2 : (k == 8'hbb ? 5 : 1))) wr(8'(k), 8'($urandom));
				rd(hdlc_map_pkg::ADDR_TX_MAP);
				rd(hdlc_map_pkg::ADDR_TX_MASK);
				repeat (150) @(posedge clk);
			end
		end
		rst <= 1'h1;
		@(posedge clk);
		rst <= 1'h0;
		rd(hdlc_map_pkg::ADDR_TX_MAP);
		repeat (4) @(posedge clk);
		results();
	end
endmodule
